/* File: rtl/flag_pkg.sv */
package flag_pkg;

   // Register port geometry
   localparam int ADDR_W = 4;
   localparam int DATA_W = 16;

   // Register offsets (word index on the plain register port)
   localparam logic [ADDR_W-1:0] OFF_GROUP3 = 4'h0;
   localparam logic [ADDR_W-1:0] OFF_GROUP4 = 4'h1;
   localparam logic [ADDR_W-1:0] OFF_EVT_STATUS = 4'h2;
   localparam logic [ADDR_W-1:0] OFF_EVT_CLEAR = 4'h3;
   localparam logic [ADDR_W-1:0] OFF_EVT_ENABLE = 4'h4;

   // Flag register geometry
   localparam int NUM_FLAG_REGS = 2;
   localparam int IDX_GROUP3 = 0;
   localparam int IDX_GROUP4 = 1;

   // Implemented bit masks; every other bit reads zero and drops writes
   localparam logic [DATA_W-1:0] GROUP3_IMPL = 16'h0003;
   localparam logic [DATA_W-1:0] GROUP4_IMPL = 16'h00F7;
   localparam logic [DATA_W-1:0] FLAGS_RESET = 16'h0000;
   localparam logic [DATA_W-1:0] ZERO_WORD = 16'h0000;

   // Field positions in the lower (G3) and upper (G4) flag registers
   localparam int G3_TIMER_SEVEN_BIT = 0;
   localparam int G3_I2C_SECOND_BIT = 1;
   localparam int G4_PWM_FAULT_B_BIT = 0;
   localparam int G4_UART_FIRST_ERR_BIT = 1;
   localparam int G4_UART_SECOND_ERR_BIT = 2;
   localparam int G4_DMA_SIX_BIT = 4;
   localparam int G4_DMA_SEVEN_BIT = 5;
   localparam int G4_CAN_FIRST_TX_BIT = 6;
   localparam int G4_CAN_SECOND_TX_BIT = 7;

   // Event status register: one bit per source, in event_t order
   localparam int NUM_SRC = 9;
   localparam logic [DATA_W-1:0] EVT_MASK = 16'h01FF;
   localparam logic [DATA_W-1:0] EVT_RESET = 16'h0000;

   // Event sources, bit 0 is timer_seven
   typedef struct packed {
      logic can_second_tx;
      logic can_first_tx;
      logic dma_ch_seven;
      logic dma_ch_six;
      logic uart_second_err;
      logic uart_first_err;
      logic pwm_fault_b;
      logic i2c_second_slave;
      logic timer_seven;
   } event_t;

   // One request on the register port
   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic wr;
      logic rd;
   } bus_req_t;

endpackage

/* File: rtl/flag_cell.sv */
`timescale 1ns/1ps
module flag_cell
(
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // Hardware event and software write
   input wire logic set_evt,
   input wire logic wr_en,
   input wire logic wr_bit,
   // Stored flag
   output logic flag_r
);

   logic flag_nxt;

   // Hardware set wins over a software write of zero in the same cycle
   always_comb
   begin
      flag_nxt = flag_r;
      if (wr_en)
      begin
         flag_nxt = wr_bit;
      end
      if (set_evt)
      begin
         flag_nxt = 1'b1;
      end
   end

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         flag_r <= 1'b0;
      end
      else
      begin
         flag_r <= flag_nxt;
      end
   end

endmodule

/* File: rtl/interrupt_flag_status_bank.sv */
`timescale 1ns/1ps
module interrupt_flag_status_bank
   import flag_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // Register port
   input wire logic [ADDR_W-1:0] addr,
   input wire logic [DATA_W-1:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [DATA_W-1:0] rdata_r,
   // Event sources, one-cycle pulses on clk
   input wire event_t events,
   // Interrupt
   output logic irq_r
);

   bus_req_t req;
   logic [DATA_W-1:0] impl_mask [NUM_FLAG_REGS];
   logic [DATA_W-1:0] flag_evt [NUM_FLAG_REGS];
   logic [DATA_W-1:0] flag_q [NUM_FLAG_REGS];
   logic [NUM_FLAG_REGS-1:0] flag_wr;
   logic [DATA_W-1:0] evt_vec;
   logic [DATA_W-1:0] evt_status_r;
   logic [DATA_W-1:0] evt_status_nxt;
   logic [DATA_W-1:0] evt_enable_r;
   event_t evt_status_view;
   event_t evt_enable_view;
   logic [DATA_W-1:0] rdata_nxt;
   logic irq_nxt;

   function automatic logic reg_hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
      reg_hit = (a == off);
   endfunction

   assign req = '{addr: addr, wdata: wdata, wr: wr, rd: rd};

   // Route each source to its flag position
   always_comb
   begin
      flag_evt[IDX_GROUP3] = ZERO_WORD;
      flag_evt[IDX_GROUP4] = ZERO_WORD;
      flag_evt[IDX_GROUP3][G3_I2C_SECOND_BIT] = events.i2c_second_slave;
      flag_evt[IDX_GROUP3][G3_TIMER_SEVEN_BIT] = events.timer_seven;
      flag_evt[IDX_GROUP4][G4_CAN_SECOND_TX_BIT] = events.can_second_tx;
      flag_evt[IDX_GROUP4][G4_CAN_FIRST_TX_BIT] = events.can_first_tx;
      flag_evt[IDX_GROUP4][G4_DMA_SEVEN_BIT] = events.dma_ch_seven;
      flag_evt[IDX_GROUP4][G4_DMA_SIX_BIT] = events.dma_ch_six;
      flag_evt[IDX_GROUP4][G4_UART_SECOND_ERR_BIT] = events.uart_second_err;
      flag_evt[IDX_GROUP4][G4_UART_FIRST_ERR_BIT] = events.uart_first_err;
      flag_evt[IDX_GROUP4][G4_PWM_FAULT_B_BIT] = events.pwm_fault_b;
   end

   assign impl_mask[IDX_GROUP3] = GROUP3_IMPL;
   assign impl_mask[IDX_GROUP4] = GROUP4_IMPL;
   assign flag_wr[IDX_GROUP3] = req.wr && reg_hit(req.addr, OFF_GROUP3);
   assign flag_wr[IDX_GROUP4] = req.wr && reg_hit(req.addr, OFF_GROUP4);

   // Only implemented bits get storage; the rest are constant zero
   for (genvar r = 0; r < NUM_FLAG_REGS; r++)
   begin : g_reg
      for (genvar b = 0; b < DATA_W; b++)
      begin : g_bit
         if ((r == IDX_GROUP3 && GROUP3_IMPL[b]) || (r == IDX_GROUP4 && GROUP4_IMPL[b]))
         begin : g_impl
            flag_cell u_cell
            (
               .clk(clk),
               .reset_n(reset_n),
               .set_evt(flag_evt[r][b]),
               .wr_en(flag_wr[r]),
               .wr_bit(req.wdata[b]),
               .flag_r(flag_q[r][b])
            );
         end
         else
         begin : g_none
            assign flag_q[r][b] = 1'b0;
         end
      end
   end

   // Sticky event status, cleared by writing ones to the clear register
   assign evt_vec = {{(DATA_W-NUM_SRC){1'b0}}, events};
   assign evt_status_view = event_t'(evt_status_r[NUM_SRC-1:0]);
   assign evt_enable_view = event_t'(evt_enable_r[NUM_SRC-1:0]);

   always_comb
   begin
      evt_status_nxt = evt_status_r;
      if (req.wr && reg_hit(req.addr, OFF_EVT_CLEAR))
      begin
         evt_status_nxt = evt_status_nxt & ~req.wdata;
      end
      // A new event in the clearing cycle is kept
      evt_status_nxt = (evt_status_nxt | evt_vec) & EVT_MASK;
   end

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         evt_status_r <= EVT_RESET;
      end
      else
      begin
         evt_status_r <= evt_status_nxt;
      end
   end

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         evt_enable_r <= EVT_RESET;
      end
      else if (req.wr && reg_hit(req.addr, OFF_EVT_ENABLE))
      begin
         evt_enable_r <= req.wdata & EVT_MASK;
      end
   end

   // Built from the next status so the flopped output rises with the status bit
   assign irq_nxt = |(evt_status_nxt & evt_enable_r);

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         irq_r <= 1'b0;
      end
      else
      begin
         irq_r <= irq_nxt;
      end
   end

   // Read data stand only in the cycle after the strobe; unmapped reads give zero
   always_comb
   begin
      rdata_nxt = ZERO_WORD;
      if (req.rd)
      begin
         if (reg_hit(req.addr, OFF_GROUP3))
         begin
            rdata_nxt = flag_q[IDX_GROUP3] & impl_mask[IDX_GROUP3];
         end
         else if (reg_hit(req.addr, OFF_GROUP4))
         begin
            rdata_nxt = flag_q[IDX_GROUP4] & impl_mask[IDX_GROUP4];
         end
         else if (reg_hit(req.addr, OFF_EVT_STATUS))
         begin
            rdata_nxt = evt_status_r;
         end
         else if (reg_hit(req.addr, OFF_EVT_ENABLE))
         begin
            rdata_nxt = evt_enable_r;
         end
      end
   end

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         rdata_r <= ZERO_WORD;
      end
      else
      begin
         rdata_r <= rdata_nxt;
      end
   end

   // Checks

   property p_flag_hold;
      @(posedge clk) disable iff (!reset_n)
      (!flag_wr[IDX_GROUP4] && flag_evt[IDX_GROUP4] == ZERO_WORD)
         |=> (flag_q[IDX_GROUP4] == $past(flag_q[IDX_GROUP4]));
   endproperty
   a_flag_hold: assert property (p_flag_hold) else $error("upper flags changed without cause");

   property p_flag_sw_clear;
      @(posedge clk) disable iff (!reset_n)
      (flag_wr[IDX_GROUP3] && req.wdata == ZERO_WORD && flag_evt[IDX_GROUP3] == ZERO_WORD)
         ##1 (!flag_wr[IDX_GROUP3] && flag_evt[IDX_GROUP3] == ZERO_WORD)
         |-> (flag_q[IDX_GROUP3] == ZERO_WORD) ##1 (flag_q[IDX_GROUP3] == ZERO_WORD);
   endproperty
   a_flag_sw_clear: assert property (p_flag_sw_clear) else $error("lower flags not cleared by write");

   property p_i2c_second;
      @(posedge clk) disable iff (!reset_n)
      events.i2c_second_slave |=> flag_q[IDX_GROUP3][G3_I2C_SECOND_BIT];
   endproperty
   a_i2c_second: assert property (p_i2c_second) else $error("i2c slave event flag not set");

   property p_timer_seven;
      @(posedge clk) disable iff (!reset_n)
      events.timer_seven |=> flag_q[IDX_GROUP3][G3_TIMER_SEVEN_BIT];
   endproperty
   a_timer_seven: assert property (p_timer_seven) else $error("timer flag not set");

   property p_can_second;
      @(posedge clk) disable iff (!reset_n)
      (events.can_second_tx && flag_wr[IDX_GROUP4]) |=> flag_q[IDX_GROUP4][G4_CAN_SECOND_TX_BIT];
   endproperty
   a_can_second: assert property (p_can_second) else $error("second can flag lost to write");

   property p_can_first;
      @(posedge clk) disable iff (!reset_n)
      events.can_first_tx ##1 (req.rd && reg_hit(req.addr, OFF_GROUP4) && !flag_wr[IDX_GROUP4])
         |=> rdata_r[G4_CAN_FIRST_TX_BIT];
   endproperty
   a_can_first: assert property (p_can_first) else $error("first can flag not read back");

   property p_dma_seven;
      @(posedge clk) disable iff (!reset_n)
      $rose(flag_q[IDX_GROUP4][G4_DMA_SEVEN_BIT])
         |-> ($past(events.dma_ch_seven) || ($past(flag_wr[IDX_GROUP4]) && $past(req.wdata[G4_DMA_SEVEN_BIT])));
   endproperty
   a_dma_seven: assert property (p_dma_seven) else $error("dma seven flag rose without cause");

   property p_dma_six;
      @(posedge clk) disable iff (!reset_n)
      events.dma_ch_six |=> flag_q[IDX_GROUP4][G4_DMA_SIX_BIT];
   endproperty
   a_dma_six: assert property (p_dma_six) else $error("dma six flag not set");

   property p_uart_second;
      @(posedge clk) disable iff (!reset_n)
      events.uart_second_err |=> flag_q[IDX_GROUP4][G4_UART_SECOND_ERR_BIT] && evt_status_view.uart_second_err;
   endproperty
   a_uart_second: assert property (p_uart_second) else $error("second uart error flag not set");

   property p_uart_first;
      @(posedge clk) disable iff (!reset_n)
      events.uart_first_err |=> flag_q[IDX_GROUP4][G4_UART_FIRST_ERR_BIT];
   endproperty
   a_uart_first: assert property (p_uart_first) else $error("first uart error flag not set");

   property p_pwm_fault;
      @(posedge clk) disable iff (!reset_n)
      events.pwm_fault_b |=> flag_q[IDX_GROUP4][G4_PWM_FAULT_B_BIT] && (irq_r || !$past(evt_enable_view.pwm_fault_b));
   endproperty
   a_pwm_fault: assert property (p_pwm_fault) else $error("pwm fault flag not set");

   property p_unimpl_zero;
      @(posedge clk) disable iff (!reset_n)
      (req.rd && reg_hit(req.addr, OFF_GROUP4))
         |=> (rdata_r & ~GROUP4_IMPL) == ZERO_WORD;
   endproperty
   a_unimpl_zero: assert property (p_unimpl_zero) else $error("unimplemented bits read nonzero");

   property p_sw_write;
      @(posedge clk) disable iff (!reset_n)
      flag_wr[IDX_GROUP4] ##1 (req.rd && reg_hit(req.addr, OFF_GROUP4) && !flag_wr[IDX_GROUP4]
         && flag_evt[IDX_GROUP4] == ZERO_WORD)
         |=> (rdata_r | $past(flag_evt[IDX_GROUP4], 2)) == (($past(req.wdata, 2) & GROUP4_IMPL)
         | $past(flag_evt[IDX_GROUP4], 2));
   endproperty
   a_sw_write: assert property (p_sw_write) else $error("upper flags not software writable");

   property p_flag_hold_low;
      @(posedge clk) disable iff (!reset_n)
      (!flag_wr[IDX_GROUP3] && flag_evt[IDX_GROUP3] == ZERO_WORD)
         |=> (flag_q[IDX_GROUP3] == $past(flag_q[IDX_GROUP3]));
   endproperty
   a_flag_hold_low: assert property (p_flag_hold_low) else $error("lower flags changed without cause");

   property p_rd_group3;
      @(posedge clk) disable iff (!reset_n)
      (req.rd && reg_hit(req.addr, OFF_GROUP3))
         |=> rdata_r == $past(flag_q[IDX_GROUP3]);
   endproperty
   a_rd_group3: assert property (p_rd_group3) else $error("lower flags not read back");

   property p_g3_unimpl;
      @(posedge clk) disable iff (!reset_n)
      (req.rd && reg_hit(req.addr, OFF_GROUP3))
         |=> (rdata_r & ~GROUP3_IMPL) == ZERO_WORD;
   endproperty
   a_g3_unimpl: assert property (p_g3_unimpl) else $error("lower unimplemented bits read nonzero");

   property p_status_set;
      @(posedge clk) disable iff (!reset_n)
      evt_vec != ZERO_WORD |=> (evt_status_r & $past(evt_vec)) == $past(evt_vec);
   endproperty
   a_status_set: assert property (p_status_set) else $error("event status bit not set");

   property p_status_clear;
      @(posedge clk) disable iff (!reset_n)
      (req.wr && reg_hit(req.addr, OFF_EVT_CLEAR) && evt_vec == ZERO_WORD)
         |=> (evt_status_r & $past(req.wdata)) == ZERO_WORD;
   endproperty
   a_status_clear: assert property (p_status_clear) else $error("event status bit not cleared");

   property p_status_quiet;
      @(posedge clk) disable iff (!reset_n)
      (!(req.wr && reg_hit(req.addr, OFF_EVT_CLEAR)) && evt_vec == ZERO_WORD)
         |=> $stable(evt_status_r);
   endproperty
   a_status_quiet: assert property (p_status_quiet) else $error("event status changed without cause");

   property p_enable_write;
      @(posedge clk) disable iff (!reset_n)
      (req.wr && reg_hit(req.addr, OFF_EVT_ENABLE))
         |=> evt_enable_r == ($past(req.wdata) & EVT_MASK);
   endproperty
   a_enable_write: assert property (p_enable_write) else $error("enable register not written");

   property p_irq_level;
      @(posedge clk) disable iff (!reset_n)
      irq_r == |(evt_status_r & $past(evt_enable_r));
   endproperty
   a_irq_level: assert property (p_irq_level) else $error("interrupt level wrong");

   property p_status_read;
      @(posedge clk) disable iff (!reset_n)
      (req.rd && reg_hit(req.addr, OFF_EVT_STATUS))
         |=> rdata_r == $past(evt_status_r);
   endproperty
   a_status_read: assert property (p_status_read) else $error("event status not read back");

   property p_clear_reads_zero;
      @(posedge clk) disable iff (!reset_n)
      (req.rd && reg_hit(req.addr, OFF_EVT_CLEAR))
         |=> rdata_r == ZERO_WORD;
   endproperty
   a_clear_reads_zero: assert property (p_clear_reads_zero) else $error("clear register read nonzero");

   property p_read_window;
      @(posedge clk) disable iff (!reset_n)
      !req.rd |=> rdata_r == ZERO_WORD;
   endproperty
   a_read_window: assert property (p_read_window) else $error("read data outside read cycle");

endmodule

/* File: dv/interrupt_flag_status_bank_bench.sv */
`timescale 1ns/1ps
module interrupt_flag_status_bank_bench
   import flag_pkg::*;
;
   logic clk;
   logic reset_n;
   logic [ADDR_W-1:0] addr;
   logic [DATA_W-1:0] wdata;
   logic wr;
   logic rd;
   logic [DATA_W-1:0] rdata_r;
   event_t events;
   logic irq_r;
   int fail_count;
   int num_checks;
   logic [DATA_W-1:0] g3, g4, st, en, d;

   interrupt_flag_status_bank dut
   (
      .clk(clk),
      .reset_n(reset_n),
      .addr(addr),
      .wdata(wdata),
      .wr(wr),
      .rd(rd),
      .rdata_r(rdata_r),
      .events(events),
      .irq_r(irq_r)
   );

   always #5 clk = ~clk;

   // Expected flag words from an event vector
   function automatic logic [DATA_W-1:0] g3_of(input logic [8:0] e);
      return {14'h0000, e[1], e[0]};
   endfunction

   function automatic logic [DATA_W-1:0] g4_of(input logic [8:0] e);
      return {8'h00, e[8], e[7], e[6], e[5], 1'b0, e[4], e[3], e[2]};
   endfunction

   task automatic check(input string name, input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
      @(posedge clk);
      addr <= a;
      wdata <= v;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask

   // Read data stand only in the cycle after the strobe
   task automatic rd_reg(input string name, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      check(name, rdata_r, exp);
   endtask

   task automatic pulse(input logic [8:0] e);
      @(posedge clk);
      events <= event_t'(e);
      @(posedge clk);
      events <= event_t'(9'h000);
      g3 = g3 | g3_of(e);
      g4 = g4 | g4_of(e);
      st = st | {7'h00, e};
   endtask

   task automatic read_all();
      rd_reg("group3", OFF_GROUP3, g3);
      rd_reg("group4", OFF_GROUP4, g4);
      rd_reg("status", OFF_EVT_STATUS, st);
      rd_reg("enable", OFF_EVT_ENABLE, en);
      rd_reg("clear", OFF_EVT_CLEAR, ZERO_WORD);
      rd_reg("unmapped", 4'hA, ZERO_WORD);
      check("irq", {15'h0000, irq_r}, {15'h0000, |(st & en)});
   endtask

   task automatic apply_reset();
      @(posedge clk);
      reset_n <= 1'b0;
      repeat (20) @(posedge clk);
      reset_n <= 1'b1;
      g3 = '0;
      g4 = '0;
      st = '0;
      en = '0;
   endtask

   initial
   begin
      #200000;
      fail_count++;
      report_and_stop();
   end

   initial
   begin
      clk = 1'b0;
      reset_n <= 1'b0;
      addr <= '0;
      wdata <= '0;
      wr <= 1'b0;
      rd <= 1'b0;
      events <= event_t'(9'h000);
      void'($urandom(67697));
      apply_reset();
      read_all();
      // Each source alone, then cleared by software
      for (int i = 0; i < NUM_SRC; i++)
      begin
         pulse(9'(1 << i));
         read_all();
         wr_reg(OFF_GROUP3, ZERO_WORD);
         wr_reg(OFF_GROUP4, ZERO_WORD);
         wr_reg(OFF_EVT_CLEAR, EVT_MASK);
         g3 = '0;
         g4 = '0;
         st = '0;
         read_all();
      end
      // Interrupt rises together with the status bit and stays
      wr_reg(OFF_EVT_ENABLE, EVT_MASK);
      en = EVT_MASK;
      #1;
      check("irq_idle", {15'h0000, irq_r}, ZERO_WORD);
      pulse(9'h020);
      #1;
      check("irq_with_status", {15'h0000, irq_r}, 16'h0001);
      @(posedge clk);
      #1;
      check("irq_held", {15'h0000, irq_r}, 16'h0001);
      wr_reg(OFF_EVT_ENABLE, 16'h01DF);
      en = 16'h01DF;
      read_all();
      wr_reg(OFF_EVT_ENABLE, EVT_MASK);
      en = EVT_MASK;
      wr_reg(OFF_EVT_CLEAR, 16'h0020);
      st = '0;
      read_all();
      // Events beat a clearing write in the same cycle; read back with no gap
      @(posedge clk);
      addr <= OFF_GROUP4;
      wdata <= ZERO_WORD;
      wr <= 1'b1;
      events <= event_t'(9'h1A0);
      @(posedge clk);
      wr <= 1'b0;
      rd <= 1'b1;
      events <= event_t'(9'h000);
      @(posedge clk);
      rd <= 1'b0;
      g4 = 16'h00D0;
      st = 16'h01A0;
      #1;
      check("group4_back_to_back", rdata_r, g4);
      read_all();
      // Random traffic; reserved bits must drop writes
      for (int n = 0; n < 40; n++)
      begin
         pulse(9'($urandom));
         read_all();
         d = 16'($urandom);
         wr_reg(OFF_GROUP3, d);
         g3 = d & GROUP3_IMPL;
         d = 16'($urandom);
         wr_reg(OFF_GROUP4, d);
         g4 = d & GROUP4_IMPL;
         d = 16'($urandom);
         wr_reg(OFF_EVT_ENABLE, d);
         en = d & EVT_MASK;
         d = 16'($urandom);
         wr_reg(OFF_EVT_CLEAR, d);
         st = st & ~d;
         wr_reg(OFF_EVT_STATUS, 16'($urandom));
         wr_reg(4'hF, 16'($urandom));
         read_all();
      end
      // Reset in mid-run clears every flag
      apply_reset();
      read_all();
      report_and_stop();
   end
endmodule
